// ===== core/acsg_pkg.sv
// package for the converter channel sequence and range configuration block
// assumes an apb slave with 32-bit data, one register per aligned word
package acsg_pkg;
    // printed offsets are word indices, byte address is four times the index
    localparam logic [7:0]  IDX_CH_EN_LOW    = 8'h50;
    localparam logic [7:0]  IDX_CH_EN_HIGH   = 8'h51;
    localparam logic [7:0]  IDX_RANGE_SEL    = 8'h52;
    localparam logic [7:0]  IDX_SEQ_CTRL     = 8'h60;
    localparam logic [7:0]  IDX_SEQ_STATUS   = 8'h61;
    localparam logic [9:0]  ADDR_CH_EN_LOW   = {IDX_CH_EN_LOW, 2'b00};
    localparam logic [9:0]  ADDR_CH_EN_HIGH  = {IDX_CH_EN_HIGH, 2'b00};
    localparam logic [9:0]  ADDR_RANGE_SEL   = {IDX_RANGE_SEL, 2'b00};
    localparam logic [9:0]  ADDR_SEQ_CTRL    = {IDX_SEQ_CTRL, 2'b00};
    localparam logic [9:0]  ADDR_SEQ_STATUS  = {IDX_SEQ_STATUS, 2'b00};
    localparam logic [15:0] RST_CH_EN_LOW    = 16'h0000;
    localparam logic [15:0] RST_CH_EN_HIGH   = 16'h0000;
    localparam logic [15:0] RST_RANGE_SEL    = 16'hffff;
    localparam logic [15:0] MASK_CH_EN_LOW   = 16'h7fff;
    localparam logic [15:0] MASK_CH_EN_HIGH  = 16'h7000;
    // field positions in the low and high enable registers
    localparam int          POS_SE0          = 14;
    localparam int          POS_SE1          = 13;
    localparam int          POS_DIFF01       = 12;
    localparam int          POS_SE2          = 11;
    localparam int          POS_SE3          = 10;
    localparam int          POS_DIFF23       = 9;
    localparam int          POS_TOP_HIGH     = 14;
    localparam int          NUM_SLOTS        = 16;
    // slot counter value after reset
    localparam logic [3:0]  RST_SEQ_COUNT    = 4'h0;

    // one conversion step handed to the conversion engine
    typedef struct packed {
        logic [3:0] pos_input;   // positive input, also the result slot
        logic [3:0] neg_input;   // negative input, differential only
        logic       diff;        // 1: differential, twos complement result
        logic       range_double;
    } acsg_step_t;

    typedef struct packed {
        logic [9:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } acsg_apb_req_t;
endpackage

// ===== core/acsg_slot_map.sv
// maps the enable and range registers to per-slot selections
// assumes the register values are stable flops in the parent
`timescale 1ns/100ps
module acsg_slot_map
    import acsg_pkg::*;
(
    input  wire logic [15:0] en_low,
    input  wire logic [15:0] en_high,
    input  wire logic [15:0] range_sel,
    output logic      [15:0] slot_active,
    output logic      [15:0] slot_diff,
    output logic      [15:0] slot_double
);
    logic pair01_single;
    logic pair23_single;

    always_comb begin
        pair01_single = en_low[POS_SE0] | en_low[POS_SE1];
        pair23_single = en_low[POS_SE2] | en_low[POS_SE3];
        slot_active   = 16'h0000;
        slot_diff     = 16'h0000;
        slot_active[0]  = en_low[POS_SE0] | (~pair01_single & en_low[POS_DIFF01]); // see (R6) (R8) (R9)
        slot_diff[0]    = ~pair01_single & en_low[POS_DIFF01];                   // see (R9)
        slot_active[1]  = en_low[POS_SE1];                                        // see (R8)
        slot_active[2]  = en_low[POS_SE2] | (~pair23_single & en_low[POS_DIFF23]); // see (R7) (R10)
        slot_diff[2]    = ~pair23_single & en_low[POS_DIFF23];                   // see (R10)
        slot_active[3]  = en_low[POS_SE3];
        for (int i = 0; i < 9; i++) begin
            slot_active[4 + i] = en_low[8 - i];                                   // see (R11)
        end
        for (int i = 0; i < 3; i++) begin
            slot_active[13 + i] = en_high[POS_TOP_HIGH - i];                      // see (R12)
        end
        // input 0 sits at the top range bit
        for (int i = 0; i < NUM_SLOTS; i++) begin
            slot_double[i] = range_sel[15 - i];                                   // see (R14) (R15) (R16)
        end
    end
endmodule

// ===== core/acsg_top.sv
// channel sequence and input range configuration with apb register access
// assumes a conversion engine that takes one step per STEP_VALID/STEP_READY handshake
// Contract
// (R1) top bit of the low enable register ignores writes and reads zero.
// (R2) enabled inputs of the low enable register convert in order from bit 14 down to bit 0.
// (R3) after the low register the sequence goes on with bits 14 to 12 of the high register.
// (R4) an input converts only when its enable bit is one, otherwise it is skipped.
// (R5) a single-ended input n gives a straight binary result in slot n.
// (R6) the first pair bit converts input 0 minus input 1, twos complement, into slot 0.
// (R7) the second pair bit converts input 2 minus input 3, twos complement, into slot 2.
// (R8) a set single-ended bit for input 0 or 1 makes the first pair bit ignored.
// (R9) pair 0/1 is differential only with both single-ended bits zero and its pair bit one.
// (R10) pair 2/3 follows the same precedence with its own bits.
// (R11) bits 8 down to 0 of the low register enable inputs 4 to 12 in that order.
// (R12) bits 14 to 12 of the high register enable inputs 13 to 15, other bits read zero.
// (R13) low enable register sits at index 50h and resets to 0000h.
// (R14) range register sits at index 52h, resets to ffffh, input 0 at the top bit.
// (R15) range bit zero gives 0 to reference span, one gives twice that span.
// (R16) a differential pair uses its positive input range bit for plus or minus span.
`timescale 1ns/100ps
module acsg_top
    import acsg_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [9:0]  PADDR,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             STEP_VALID,
    input  wire logic        STEP_READY,
    output acsg_step_t       STEP,
    output logic             SEQ_BUSY
);
    typedef enum {ST_IDLE, ST_SCAN, ST_ISSUE} acsg_state_t;

    logic [15:0] en_low_q, en_low_d;
    logic [15:0] en_high_q, en_high_d;
    logic [15:0] range_q, range_d;
    logic        run_q, run_d;
    logic        cont_q, cont_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    acsg_state_t state_q, state_d;
    logic [3:0]  slot_q, slot_d;
    logic        step_valid_q, step_valid_d;
    acsg_step_t  step_q, step_d;
    logic        busy_q, busy_d;
    logic [15:0] slot_active;
    logic [15:0] slot_diff;
    logic [15:0] slot_double;
    acsg_apb_req_t req;
    logic        acc;
    logic        start_pulse;

    acsg_slot_map u_map (
        .en_low      (en_low_q),
        .en_high     (en_high_q),
        .range_sel   (range_q),
        .slot_active (slot_active),
        .slot_diff   (slot_diff),
        .slot_double (slot_double)
    );

    assign req = '{paddr: PADDR, psel: PSEL, penable: PENABLE, pwrite: PWRITE, pwdata: PWDATA};
    // one wait state: PREADY is registered and answers in the second access cycle
    assign acc = req.psel & req.penable & ~pready_q;

    always_comb begin
        en_low_d    = en_low_q;
        en_high_d   = en_high_q;
        range_d     = range_q;
        run_d       = 1'b0;
        cont_d      = cont_q;
        prdata_d    = 32'h0000_0000;
        pready_d    = acc;
        pslverr_d   = 1'b0;
        start_pulse = 1'b0;
        if (acc) begin
            case (req.paddr)
                ADDR_CH_EN_LOW: begin
                    if (req.pwrite) begin
                        en_low_d = req.pwdata[15:0] & MASK_CH_EN_LOW; // see (R1) (R13)
                    end
                    prdata_d = {16'h0000, en_low_q};
                end
                ADDR_CH_EN_HIGH: begin
                    if (req.pwrite) begin
                        en_high_d = req.pwdata[15:0] & MASK_CH_EN_HIGH; // see (R12)
                    end
                    prdata_d = {16'h0000, en_high_q};
                end
                ADDR_RANGE_SEL: begin
                    if (req.pwrite) begin
                        range_d = req.pwdata[15:0]; // see (R14)
                    end
                    prdata_d = {16'h0000, range_q};
                end
                ADDR_SEQ_CTRL: begin
                    if (req.pwrite) begin
                        start_pulse = req.pwdata[0];
                        cont_d      = req.pwdata[1];
                    end
                    prdata_d = {30'h0, cont_q, 1'b0};
                end
                ADDR_SEQ_STATUS: begin
                    prdata_d = {27'h0, slot_q, busy_q};
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        run_d = start_pulse;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_low_q  <= RST_CH_EN_LOW;
            en_high_q <= RST_CH_EN_HIGH;
            range_q   <= RST_RANGE_SEL;
            run_q     <= 1'b0;
            cont_q    <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            en_low_q  <= en_low_d;
            en_high_q <= en_high_d;
            range_q   <= range_d;
            run_q     <= run_d;
            cont_q    <= cont_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // slot n walks 0..15: bits 14..0 of low (pair bits 12 and 9 fold into slots 0 and 2), then 14..12 of high
    always_comb begin
        state_d      = state_q;
        slot_d       = slot_q;
        step_valid_d = step_valid_q;
        step_d       = step_q;
        busy_d       = busy_q;
        case (state_q)
            ST_IDLE: begin
                if (run_q | cont_q) begin
                    state_d = ST_SCAN;
                    slot_d  = 4'h0;
                    busy_d  = 1'b1;
                end
            end
            ST_SCAN: begin
                if (slot_active[slot_q]) begin // see (R4)
                    state_d      = ST_ISSUE;
                    step_valid_d = 1'b1;
                    step_d.pos_input    = slot_q; // see (R5) (R6) (R7)
                    step_d.diff         = slot_diff[slot_q];
                    step_d.neg_input    = slot_diff[slot_q] ? slot_q + 4'h1 : 4'h0;
                    step_d.range_double = slot_double[slot_q]; // see (R16)
                end else if (slot_q == 4'hf) begin // see (R3)
                    state_d = ST_IDLE;
                    busy_d  = 1'b0;
                end else begin
                    slot_d = slot_q + 4'h1; // see (R2)
                end
            end
            ST_ISSUE: begin
                if (STEP_READY) begin
                    step_valid_d = 1'b0;
                    if (slot_q == 4'hf) begin
                        state_d = ST_IDLE;
                        busy_d  = 1'b0;
                    end else begin
                        state_d = ST_SCAN;
                        slot_d  = slot_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q      <= ST_IDLE;
            slot_q       <= RST_SEQ_COUNT;
            step_valid_q <= 1'b0;
            step_q       <= '0;
            busy_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            slot_q       <= slot_d;
            step_valid_q <= step_valid_d;
            step_q       <= step_d;
            busy_q       <= busy_d;
        end
    end

    assign PRDATA     = prdata_q;
    assign PREADY     = pready_q;
    assign PSLVERR    = pslverr_q;
    assign STEP_VALID = step_valid_q;
    assign STEP       = step_q;
    assign SEQ_BUSY   = busy_q;

    a_top_bit_zero: assert property (@(posedge CLK) disable iff (!RST_N) en_low_q[15] == 1'b0) // see (R1)
        else $error("top enable bit set");
    a_high_bits_zero: assert property (@(posedge CLK) disable iff (!RST_N) // see (R12)
        (en_high_q & ~MASK_CH_EN_HIGH) == 16'h0000)
        else $error("unused high enable bits set");
    a_step_enabled: assert property (@(posedge CLK) disable iff (!RST_N) // see (R4)
        $rose(STEP_VALID) |-> $past(slot_active[slot_q]))
        else $error("step issued for disabled input");
    a_step_order: assert property (@(posedge CLK) disable iff (!RST_N) // see (R2)
        (STEP_VALID && STEP_READY && slot_q != 4'hf) |=> slot_q == $past(slot_q) + 4'h1)
        else $error("sequence order broken");
    a_diff01_prec: assert property (@(posedge CLK) disable iff (!RST_N) // see (R8)
        (en_low_q[POS_SE0] | en_low_q[POS_SE1]) |-> !slot_diff[0])
        else $error("pair 0/1 differential despite single-ended");
    a_diff23_prec: assert property (@(posedge CLK) disable iff (!RST_N) // see (R10)
        slot_diff[2] |-> (!en_low_q[POS_SE2] && !en_low_q[POS_SE3] && en_low_q[POS_DIFF23]))
        else $error("pair 2/3 differential precedence broken");
    a_diff_slots: assert property (@(posedge CLK) disable iff (!RST_N) // see (R6) (R7)
        (STEP_VALID && STEP.diff) |-> (STEP.pos_input inside {4'h0, 4'h2}) && STEP.neg_input == STEP.pos_input + 4'h1)
        else $error("differential step wrong slot");
    a_diff01_on: assert property (@(posedge CLK) disable iff (!RST_N) // see (R9)
        (en_low_q[14:12] == 3'b001) |-> (slot_diff[0] && slot_active[0]))
        else $error("pair 0/1 not differential");
    a_input_map: assert property (@(posedge CLK) disable iff (!RST_N) // see (R11)
        slot_active[12] == en_low_q[0] && slot_active[4] == en_low_q[8])
        else $error("single-ended map wrong");
    a_range_map: assert property (@(posedge CLK) disable iff (!RST_N) // see (R14) (R15)
        $rose(STEP_VALID) |-> STEP.range_double == range_q[4'hf - STEP.pos_input])
        else $error("range bit mismatch");
    a_slot_result: assert property (@(posedge CLK) disable iff (!RST_N) // see (R5)
        (STEP_VALID && !STEP.diff) |-> slot_active[STEP.pos_input])
        else $error("single-ended slot mismatch");
    a_reset_vals: assert property (@(posedge CLK) $rose(RST_N) |-> en_low_q == RST_CH_EN_LOW) // see (R13)
        else $error("reset value wrong");
    a_end_high: assert property (@(posedge CLK) disable iff (!RST_N) // see (R3)
        (state_q == ST_SCAN && slot_q == 4'hf && !slot_active[15]) |=> !SEQ_BUSY)
        else $error("sequence did not end after input 15");
    a_last_taken: assert property (@(posedge CLK) disable iff (!RST_N) // see (R3)
        (state_q == ST_ISSUE && STEP_READY && slot_q == 4'hf) |=> !SEQ_BUSY)
        else $error("sequence did not end after last step");
    a_start_scan: assert property (@(posedge CLK) disable iff (!RST_N) // see (R2)
        (run_q && state_q == ST_IDLE) |=> (state_q == ST_SCAN && slot_q == 4'h0 && SEQ_BUSY))
        else $error("pass did not start at input 0");
    a_skip_disabled: assert property (@(posedge CLK) disable iff (!RST_N) // see (R4)
        (state_q == ST_SCAN && !slot_active[slot_q] && slot_q != 4'hf) |=> slot_q == $past(slot_q) + 4'h1)
        else $error("disabled input not skipped");
    a_se_neg_zero: assert property (@(posedge CLK) disable iff (!RST_N) // see (R5)
        (STEP_VALID && !STEP.diff) |-> STEP.neg_input == 4'h0)
        else $error("single-ended step has a negative input");
    a_se1_only: assert property (@(posedge CLK) disable iff (!RST_N) // see (R8)
        (en_low_q[14:12] == 3'b010) |-> (slot_active[1] && !slot_active[0] && !slot_diff[0]))
        else $error("input 1 alone not single-ended");
    a_diff23_on: assert property (@(posedge CLK) disable iff (!RST_N) // see (R10)
        (en_low_q[11:9] == 3'b001) |-> (slot_diff[2] && slot_active[2] && !slot_active[3]))
        else $error("pair 2/3 not differential");
    a_high_map: assert property (@(posedge CLK) disable iff (!RST_N) // see (R12)
        slot_active[15:13] == {en_high_q[12], en_high_q[13], en_high_q[14]})
        else $error("high enable map wrong");
    // step handshake: an offered step must not move before it is taken
    a_valid_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        (STEP_VALID && !STEP_READY) |=> (STEP_VALID && $stable(STEP)))
        else $error("step dropped before taken");
    a_valid_busy: assert property (@(posedge CLK) disable iff (!RST_N)
        STEP_VALID |-> SEQ_BUSY)
        else $error("step offered while not busy");
    a_idle_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_IDLE |-> (!STEP_VALID && !SEQ_BUSY))
        else $error("idle sequencer not quiet");
    a_issue_valid: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_ISSUE |-> STEP_VALID)
        else $error("issue state without valid");
    // bus side: registered answer, so exactly one wait state and a one-cycle ready
    a_ready_answer: assert property (@(posedge CLK) disable iff (!RST_N)
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("access not answered");
    a_ready_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
        PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_data: assert property (@(posedge CLK) disable iff (!RST_N)
        PSLVERR |-> (PREADY && PRDATA == 32'h0000_0000))
        else $error("error answer malformed");
    a_low_write: assert property (@(posedge CLK) disable iff (!RST_N) // see (R1)
        (PSEL && PENABLE && !PREADY && PWRITE && PADDR == ADDR_CH_EN_LOW)
        |=> en_low_q == ($past(PWDATA[15:0]) & MASK_CH_EN_LOW))
        else $error("low enable write wrong");
    a_high_write: assert property (@(posedge CLK) disable iff (!RST_N) // see (R12)
        (PSEL && PENABLE && !PREADY && PWRITE && PADDR == ADDR_CH_EN_HIGH)
        |=> en_high_q == ($past(PWDATA[15:0]) & MASK_CH_EN_HIGH))
        else $error("high enable write wrong");
    a_range_write: assert property (@(posedge CLK) disable iff (!RST_N) // see (R14)
        (PSEL && PENABLE && !PREADY && PWRITE && PADDR == ADDR_RANGE_SEL)
        |=> range_q == $past(PWDATA[15:0]))
        else $error("range write wrong");
endmodule

// ===== testbench/acsg_engine_model.sv
// conversion engine model on the step handshake
// assumes valid holds until taken; WAIT_CYC sets how slowly steps are taken
`timescale 1ns/100ps
module acsg_engine_model
    import acsg_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       STEP_VALID,
    input  acsg_step_t      STEP,
    input  wire logic [3:0] WAIT_CYC,
    output logic            STEP_READY
);
    logic [3:0] cnt_q;

    // ready only while asked, so a stuck valid cannot slip through
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q      <= 4'h0;
            STEP_READY <= 1'b0;
        end else if (STEP_VALID && !STEP_READY) begin
            if (cnt_q >= WAIT_CYC) begin
                STEP_READY <= 1'b1;
                cnt_q      <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else begin
            STEP_READY <= 1'b0;
        end
    end
endmodule

// ===== testbench/adc_channel_sequence_gain_config_bench.sv
// bench for the channel sequence and range block
// assumes the engine model on the step port; this module is the apb master
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module adc_channel_sequence_gain_config_bench;
    import acsg_pkg::*;
    typedef struct {logic [15:0] lo, hi, rg, lo_rd, hi_rd; logic [3:0] wt;} acsg_row_t;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        step_valid, step_ready, seq_busy, er;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  wt;
    acsg_step_t  step;
    acsg_step_t  seen[$];
    logic [5:0]  exp_q[$];
    int          err_count = 0;
    int          checks = 0;
    int          wn;
    // slow engine on some rows, diff pairs, ignored pair bits, empty pass
    acsg_row_t   rows[5] = '{
        '{16'hffff, 16'hffff, 16'h0000, 16'h7fff, 16'h7000, 4'h0},
        '{16'h1200, 16'h0000, 16'h8000, 16'h1200, 16'h0000, 4'h3},
        '{16'h5600, 16'h5000, 16'h1234, 16'h5600, 16'h5000, 4'h1},
        '{16'h2155, 16'h8fff, 16'hffff, 16'h2155, 16'h0000, 4'h0},
        '{16'h0000, 16'h0000, 16'h5a5a, 16'h0000, 16'h0000, 4'h2}};

    acsg_top DUT (.CLK(clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .STEP_VALID(step_valid), .STEP_READY(step_ready), .STEP(step), .SEQ_BUSY(seq_busy));
    acsg_engine_model ENG (.CLK(clk), .RST_N(rst_n), .STEP_VALID(step_valid), .STEP(step),
        .WAIT_CYC(wt), .STEP_READY(step_ready));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (step_valid === 1'b1 && step_ready === 1'b1) seen.push_back(step);
    end

    task automatic print_verdict();
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready)
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected {slot, diff, range} list from the enable and range values
    function automatic void build(input logic [15:0] lo, hi, rg);
        logic en, df;
        exp_q.delete();
        for (int n = 0; n < 16; n++) begin
            df = 1'b0;
            case (n)
                0: begin
                    en = lo[14] | (lo[12] & ~lo[13]);
                    df = ~lo[14] & ~lo[13] & lo[12];
                end
                1: en = lo[13];
                2: begin
                    en = lo[11] | (lo[9] & ~lo[10]);
                    df = ~lo[11] & ~lo[10] & lo[9];
                end
                3: en = lo[10];
                default: en = (n < 13) ? lo[12 - n] : hi[27 - n];
            endcase
            if (en) exp_q.push_back({n[3:0], df, rg[15 - n]});
        end
    endfunction

    task automatic run_pass(input logic [15:0] lo, hi, rg);
        int n;
        logic [31:0] r;
        logic e;
        build(lo, hi, rg);
        seen.delete();
        apb(1'b1, ADDR_SEQ_CTRL, 32'h0000_0001, r, e);
        repeat (3) @(posedge clk);
        n = 0;
        while (seq_busy !== 1'b0 && n < 400) begin @(posedge clk); n++; end
        `CHK("pass end", 1'b0, seq_busy)
        `CHK("step count", exp_q.size(), seen.size())
        foreach (exp_q[i]) if (i < seen.size())
            `CHK("step", exp_q[i], {seen[i].pos_input, seen[i][1:0]})
    endtask

    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 10'h000; pwdata = 32'h0; wt = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        `CHK("busy at reset", 1'b0, seq_busy)
        `CHK("valid at reset", 1'b0, step_valid)
        apb(1'b0, ADDR_CH_EN_LOW, 32'h0, rd, er);
        `CHK("low reset", 32'h0000_0000, rd)
        apb(1'b0, ADDR_CH_EN_HIGH, 32'h0, rd, er);
        `CHK("high reset", 32'h0000_0000, rd)
        apb(1'b0, ADDR_RANGE_SEL, 32'h0, rd, er);
        `CHK("range reset", 32'h0000_ffff, rd)
        foreach (rows[i]) begin
            wt <= rows[i].wt;
            apb(1'b1, ADDR_CH_EN_LOW, {16'h0, rows[i].lo}, rd, er);
            apb(1'b1, ADDR_CH_EN_HIGH, {16'h0, rows[i].hi}, rd, er);
            apb(1'b1, ADDR_RANGE_SEL, {16'h0, rows[i].rg}, rd, er);
            apb(1'b0, ADDR_CH_EN_LOW, 32'h0, rd, er);
            `CHK("low readback", {16'h0, rows[i].lo_rd}, rd)
            apb(1'b0, ADDR_CH_EN_HIGH, 32'h0, rd, er);
            `CHK("high readback", {16'h0, rows[i].hi_rd}, rd)
            apb(1'b0, ADDR_RANGE_SEL, 32'h0, rd, er);
            `CHK("range readback", {16'h0, rows[i].rg}, rd)
            run_pass(rows[i].lo, rows[i].hi, rows[i].rg);
        end
        // unmapped place answers with an error and reads zero
        apb(1'b1, 10'h3fc, 32'hffff_ffff, rd, er);
        `CHK("unmapped write err", 1'b1, er)
        apb(1'b0, 10'h3fc, 32'h0, rd, er);
        `CHK("unmapped read err", 1'b1, er)
        `CHK("unmapped read data", 32'h0000_0000, rd)
        // continuous mode keeps repeating passes until its bit is cleared
        apb(1'b1, ADDR_CH_EN_LOW, 32'h0000_0100, rd, er);
        build(16'h0100, 16'h0000, 16'h5a5a);
        seen.delete();
        apb(1'b1, ADDR_SEQ_CTRL, 32'h0000_0002, rd, er);
        apb(1'b0, ADDR_SEQ_CTRL, 32'h0, rd, er);
        `CHK("ctrl readback", 32'h0000_0002, rd)
        repeat (60) @(posedge clk);
        apb(1'b1, ADDR_SEQ_CTRL, 32'h0, rd, er);
        wn = 0;
        while (seq_busy !== 1'b0 && wn < 100) begin @(posedge clk); wn++; end
        `CHK("cont end", 1'b0, seq_busy)
        `CHK("cont passes", 1'b1, seen.size() >= 2)
        foreach (seen[i]) `CHK("cont step", exp_q[0], {seen[i].pos_input, seen[i][1:0]})
        apb(1'b0, ADDR_SEQ_STATUS, 32'h0, rd, er);
        `CHK("status idle", 32'h0000_001e, rd)
        // reset in mid-pass restores the defaults
        apb(1'b1, ADDR_CH_EN_LOW, 32'h0000_7fff, rd, er);
        apb(1'b1, ADDR_SEQ_CTRL, 32'h0000_0001, rd, er);
        repeat (6) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        `CHK("valid after reset", 1'b0, step_valid)
        `CHK("busy after reset", 1'b0, seq_busy)
        `CHK("ready after reset", 1'b0, pready)
        apb(1'b0, ADDR_CH_EN_LOW, 32'h0, rd, er);
        `CHK("low after reset", 32'h0000_0000, rd)
        apb(1'b0, ADDR_RANGE_SEL, 32'h0, rd, er);
        `CHK("range after reset", 32'h0000_ffff, rd)
        print_verdict();
    end
endmodule
